// ===== rtl/scpb_top.sv
// System control register upper fields with privilege-gated writes
`timescale 1ns/10ps
`include "scpb_consts.svh"
module scpb_top #(
  parameter logic [31:0] PROG_MEM_BYTES = 32'h0001_0000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scpb_pkg::scpb_ctx_type ctx,
  input wire logic sys_pw_matched,
  input wire logic ldr_pw_matched,
  input wire logic debug_cmd_req,
  input wire logic mem_access_req,
  input wire logic mem_access_allowed,
  input wire logic util_rom_read,
  output scpb_pkg::scpb_ctrl_type ctrl,
  output logic sys_routine_grant,
  output logic ldr_routine_grant,
  output logic debug_cmd_refused,
  output logic access_grant,
  output logic prot_fault
);
  logic [15:0] sc_r;
  logic [15:0] sc_nxt;
  logic [15:0] rd_nxt;
  logic wr_sc;
  logic page_hi_ok;
  logic page_lo_ok;
  logic high_rom;
  logic med_rom;

  // Access phase only; single-cycle answer, no wait states
  assign wr_sc = psel && penable && pwrite && (paddr == `SCPB_SC_ADDR);
  assign page_hi_ok = PROG_MEM_BYTES > `SCPB_MEM_64K;
  assign page_lo_ok = PROG_MEM_BYTES > `SCPB_MEM_32K;
  assign high_rom = ctx.in_util_rom &&
    (ctx.current_privilege_level == scpb_pkg::SCPB_CURRENT_PRIVILEGE_LEVEL_HIGH);
  assign med_rom = ctx.in_util_rom &&
    (ctx.current_privilege_level >= scpb_pkg::SCPB_CURRENT_PRIVILEGE_LEVEL_MED);

  // Byte-lane merge of write data into a register word
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
    input logic [15:0] wd, input logic [1:0] be);
    lane_merge = old;
    if (be[0])
    begin
      lane_merge[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      lane_merge[15:8] = wd[15:8];
    end
  endfunction

  always_comb
  begin
    logic [15:0] w;
    w = lane_merge(sc_r, pwdata[15:0], pstrb[1:0]);
    sc_nxt = sc_r;
    if (wr_sc)
    begin
      // Page bits only exist where memory is large enough
      if (page_hi_ok)
      begin
        sc_nxt[`SCPB_CDA_HI_BIT] = w[`SCPB_CDA_HI_BIT];
      end
      if (page_lo_ok)
      begin
        sc_nxt[`SCPB_CDA_LO_BIT] = w[`SCPB_CDA_LO_BIT];
      end
      sc_nxt[`SCPB_TAP_BIT] = w[`SCPB_TAP_BIT];
      if (high_rom)
      begin
        sc_nxt[`SCPB_SYSTEM_PASSWORD_LOCK_BIT] = w[`SCPB_SYSTEM_PASSWORD_LOCK_BIT];
      end
      if (med_rom)
      begin
        sc_nxt[`SCPB_LOADER_PASSWORD_LOCK_BIT] = w[`SCPB_LOADER_PASSWORD_LOCK_BIT];
      end
      // Setting is always allowed; only clearing needs high privilege
      if (w[`SCPB_MPE_BIT] ||
        ctx.current_privilege_level == scpb_pkg::SCPB_CURRENT_PRIVILEGE_LEVEL_HIGH)
      begin
        sc_nxt[`SCPB_MPE_BIT] = w[`SCPB_MPE_BIT];
      end
    end
  end

  // Every reset is one input here, so power-on and power-fail act alike
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sc_r <= `SCPB_RESET_VAL;
    end
    else
    begin
      sc_r <= sc_nxt;
    end
  end

  always_comb
  begin
    rd_nxt = 16'h0000;
    if (paddr == `SCPB_SC_ADDR)
    begin
      rd_nxt = sc_r;
    end
    else if (paddr == `SCPB_ST_ADDR)
    begin
      rd_nxt = {14'h0000, debug_cmd_refused, prot_fault};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr != `SCPB_SC_ADDR) &&
        (paddr != `SCPB_ST_ADDR);
      prdata <= (psel && !penable && !pwrite) ? {16'h0000, rd_nxt} :
        32'h0000_0000;
    end
  end

  // Registered copies so outputs come straight from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '{2'b00, 1'b1, 1'b1, 1'b1, 1'b1};
    end
    else
    begin
      ctrl.code_page <= {sc_nxt[`SCPB_CDA_HI_BIT], sc_nxt[`SCPB_CDA_LO_BIT]};
      ctrl.tap_enable <= sc_nxt[`SCPB_TAP_BIT];
      ctrl.system_password_lock <= sc_nxt[`SCPB_SYSTEM_PASSWORD_LOCK_BIT];
      ctrl.loader_password_lock <= sc_nxt[`SCPB_LOADER_PASSWORD_LOCK_BIT];
      ctrl.mem_protect_enable <= sc_nxt[`SCPB_MPE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_routine_grant <= 1'b0;
      ldr_routine_grant <= 1'b0;
      debug_cmd_refused <= 1'b0;
    end
    else
    begin
      sys_routine_grant <= !sc_r[`SCPB_SYSTEM_PASSWORD_LOCK_BIT] || sys_pw_matched;
      ldr_routine_grant <= !sc_r[`SCPB_LOADER_PASSWORD_LOCK_BIT] || ldr_pw_matched;
      // Programmed word locks debug no matter what the lock bits say
      debug_cmd_refused <= debug_cmd_req &&
        (ctx.flash_word_0e != `SCPB_FLASH_ERASED);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      access_grant <= 1'b0;
      prot_fault <= 1'b0;
    end
    else
    begin
      access_grant <= util_rom_read || !sc_r[`SCPB_MPE_BIT] ||
        (mem_access_req && mem_access_allowed);
      prot_fault <= sc_r[`SCPB_MPE_BIT] && mem_access_req &&
        !mem_access_allowed && !util_rom_read;
    end
  end

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    sc_r[15:11] == 5'h00 && !sc_r[6] && sc_r[3:0] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits nonzero");

  property p_system_password_lock_guard;
    @(posedge pclk) disable iff (!presetn)
    $changed(sc_r[`SCPB_SYSTEM_PASSWORD_LOCK_BIT]) |-> $past(high_rom);
  endproperty
  a_system_password_lock_guard: assert property (p_system_password_lock_guard)
    else $error("system lock changed without privilege");

  property p_loader_password_lock_guard;
    @(posedge pclk) disable iff (!presetn)
    $changed(sc_r[`SCPB_LOADER_PASSWORD_LOCK_BIT]) |-> $past(med_rom);
  endproperty
  a_loader_password_lock_guard: assert property (p_loader_password_lock_guard)
    else $error("loader lock changed without privilege");

  property p_mpe_clear;
    @(posedge pclk) disable iff (!presetn)
    $fell(sc_r[`SCPB_MPE_BIT]) |->
      $past(ctx.current_privilege_level) == scpb_pkg::SCPB_CURRENT_PRIVILEGE_LEVEL_HIGH;
  endproperty
  a_mpe_clear: assert property (p_mpe_clear)
    else $error("protection cleared at low privilege");

  property p_debug_refuse;
    @(posedge pclk) disable iff (!presetn)
    debug_cmd_req && ctx.flash_word_0e != `SCPB_FLASH_ERASED
      |=> debug_cmd_refused;
  endproperty
  a_debug_refuse: assert property (p_debug_refuse)
    else $error("debug not refused");

  property p_no_fault_off;
    @(posedge pclk) disable iff (!presetn)
    !sc_r[`SCPB_MPE_BIT] |=> !prot_fault && access_grant;
  endproperty
  a_no_fault_off: assert property (p_no_fault_off)
    else $error("fault while protection off");

  property p_rom_read;
    @(posedge pclk) disable iff (!presetn)
    util_rom_read |=> access_grant && !prot_fault;
  endproperty
  a_rom_read: assert property (p_rom_read)
    else $error("utility ROM read blocked");

  property p_sys_lock;
    @(posedge pclk) disable iff (!presetn)
    sc_r[`SCPB_SYSTEM_PASSWORD_LOCK_BIT] && !sys_pw_matched |=> !sys_routine_grant;
  endproperty
  a_sys_lock: assert property (p_sys_lock)
    else $error("system routine granted while locked");

  property p_ldr_lock;
    @(posedge pclk) disable iff (!presetn)
    sc_r[`SCPB_LOADER_PASSWORD_LOCK_BIT] && !ldr_pw_matched |=> !ldr_routine_grant;
  endproperty
  a_ldr_lock: assert property (p_ldr_lock)
    else $error("loader routine granted while locked");

  property p_pages;
    @(posedge pclk) disable iff (!presetn)
    (page_hi_ok || !sc_r[`SCPB_CDA_HI_BIT]) &&
    (page_lo_ok || !sc_r[`SCPB_CDA_LO_BIT]);
  endproperty
  a_pages: assert property (p_pages)
    else $error("absent page bit set");

  property p_fault_on;
    @(posedge pclk) disable iff (!presetn)
    sc_r[`SCPB_MPE_BIT] && mem_access_req && !mem_access_allowed &&
      !util_rom_read |=> prot_fault;
  endproperty
  a_fault_on: assert property (p_fault_on)
    else $error("no fault while protected");

  property p_cov_mpe_off;
    @(posedge pclk) disable iff (!presetn) $fell(sc_r[`SCPB_MPE_BIT]);
  endproperty
  c_mpe_off: cover property (p_cov_mpe_off);

  property p_cov_system_password_lock_clear;
    @(posedge pclk) disable iff (!presetn) $fell(sc_r[`SCPB_SYSTEM_PASSWORD_LOCK_BIT]);
  endproperty
  c_system_password_lock_clear: cover property (p_cov_system_password_lock_clear);

  property p_cov_refuse;
    @(posedge pclk) disable iff (!presetn) debug_cmd_refused;
  endproperty
  c_refuse: cover property (p_cov_refuse);

  property p_pready_one;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready;
  endproperty
  a_pready_one: assert property (p_pready_one)
    else $error("no ready after setup");

  property p_pready_drop;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_pready_drop: assert property (p_pready_drop)
    else $error("ready held past access");

  property p_write_only;
    @(posedge pclk) disable iff (!presetn)
    $changed(sc_r) |-> $past(wr_sc);
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("register changed without write");

  property p_ctrl_mirror;
    @(posedge pclk) disable iff (!presetn)
    ctrl.code_page == {sc_r[`SCPB_CDA_HI_BIT], sc_r[`SCPB_CDA_LO_BIT]} &&
      ctrl.tap_enable == sc_r[`SCPB_TAP_BIT] &&
      ctrl.system_password_lock == sc_r[`SCPB_SYSTEM_PASSWORD_LOCK_BIT] &&
      ctrl.loader_password_lock == sc_r[`SCPB_LOADER_PASSWORD_LOCK_BIT] &&
      ctrl.mem_protect_enable == sc_r[`SCPB_MPE_BIT];
  endproperty
  a_ctrl_mirror: assert property (p_ctrl_mirror)
    else $error("control outputs differ from register");

  property p_sys_open;
    @(posedge pclk) disable iff (!presetn)
    !sc_r[`SCPB_SYSTEM_PASSWORD_LOCK_BIT] |=> sys_routine_grant;
  endproperty
  a_sys_open: assert property (p_sys_open)
    else $error("system routine refused while unlocked");

  property p_ldr_open;
    @(posedge pclk) disable iff (!presetn)
    !sc_r[`SCPB_LOADER_PASSWORD_LOCK_BIT] |=> ldr_routine_grant;
  endproperty
  a_ldr_open: assert property (p_ldr_open)
    else $error("loader routine refused while unlocked");

  property p_debug_erased;
    @(posedge pclk) disable iff (!presetn)
    ctx.flash_word_0e == `SCPB_FLASH_ERASED |=> !debug_cmd_refused;
  endproperty
  a_debug_erased: assert property (p_debug_erased)
    else $error("debug refused with erased word");

  property p_cov_loader_password_lock_clear;
    @(posedge pclk) disable iff (!presetn) $fell(sc_r[`SCPB_LOADER_PASSWORD_LOCK_BIT]);
  endproperty
  c_loader_password_lock_clear: cover property (p_cov_loader_password_lock_clear);

  property p_cov_fault;
    @(posedge pclk) disable iff (!presetn) prot_fault;
  endproperty
  c_fault: cover property (p_cov_fault);
endmodule // scpb_top

// ===== rtl/scpb_consts.svh
// Constants for the system control protection bits block
// Operation
// - Upper code page bit reads zero on parts with 64KB program memory or less
// - Lower code page bit reads zero on parts with 32KB program memory or less
// - Bit 6 is reserved and always reads zero
// - Bit 7 enables test port pins; set at reset, zero disables
// - Both password lock bits set by power-on and power-fail reset
// - System lock set requires system password for debug and loader routines
// - System lock written only by utility ROM code at high privilege
// - Loader lock set requires loader password for debug and loader routines
// - Loader lock written only by utility ROM code at medium privilege or more
// - ROM debug commands refused when flash word 000Eh is not FFFFh
// - Protection enable bit set to one by every reset
// - Protection enable one enforces protection and access control
// - Protection enable zero: no fault interrupts, any code may access
// - Clearing protection enable takes effect only at high privilege
// - Utility ROM reads always permitted
// - Bits 11 to 15 reserved and read zero
`ifndef SCPB_CONSTS_SVH
`define SCPB_CONSTS_SVH
`define SCPB_SC_ADDR 12'h000
`define SCPB_ST_ADDR 12'h004
`define SCPB_CDA_LO_BIT 4
`define SCPB_CDA_HI_BIT 5
`define SCPB_TAP_BIT 7
`define SCPB_SYSTEM_PASSWORD_LOCK_BIT 8
`define SCPB_LOADER_PASSWORD_LOCK_BIT 9
`define SCPB_MPE_BIT 10
`define SCPB_RESET_VAL 16'h0780
`define SCPB_MEM_64K 32'h0001_0000
`define SCPB_MEM_32K 32'h0000_8000
`define SCPB_FLASH_ERASED 16'hffff
`define SCPB_PW_BYTES 6'h20
`endif

// ===== rtl/scpb_pkg.sv
// Types for the system control protection bits block
package scpb_pkg;
  typedef enum logic [1:0] {
    SCPB_CURRENT_PRIVILEGE_LEVEL_LOW = 2'b00,
    SCPB_CURRENT_PRIVILEGE_LEVEL_MED = 2'b01,
    SCPB_CURRENT_PRIVILEGE_LEVEL_HIGH = 2'b10
  } scpb_current_privilege_level_type;
  typedef struct packed {
    logic [1:0] code_page;
    logic tap_enable;
    logic system_password_lock;
    logic loader_password_lock;
    logic mem_protect_enable;
  } scpb_ctrl_type;
  typedef struct packed {
    logic in_util_rom;
    logic [1:0] current_privilege_level;
    logic [15:0] flash_word_0e;
  } scpb_ctx_type;
endpackage

// ===== test/scpb_tb.sv
// Register-level testbench for the system control protection bits
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  scpb_pkg::scpb_ctx_type ctx = {1'b0, 2'b00, 16'hffff};
  logic sys_m = 1'b0;
  logic ldr_m = 1'b0;
  logic dbg_req = 1'b0;
  logic m_req = 1'b0;
  logic m_ok = 1'b0;
  logic rom_rd = 1'b0;
  scpb_pkg::scpb_ctrl_type ctrl;
  logic sys_g;
  logic ldr_g;
  logic dbg_ref;
  logic acc_g;
  logic fault;
  int n_mismatch = 0;
  int num_checks = 0;

  always #2.5 pclk = ~pclk;

  scpb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctx(ctx), .sys_pw_matched(sys_m), .ldr_pw_matched(ldr_m),
    .debug_cmd_req(dbg_req), .mem_access_req(m_req),
    .mem_access_allowed(m_ok), .util_rom_read(rom_rd), .ctrl(ctrl),
    .sys_routine_grant(sys_g), .ldr_routine_grant(ldr_g),
    .debug_cmd_refused(dbg_ref), .access_grant(acc_g),
    .prot_fault(fault));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_ctx(input logic rom, input logic [1:0] pl,
    input logic [31:0] d);
    logic [31:0] q;
    logic e;
    @(posedge pclk);
    ctx <= {rom, pl, 16'hffff};
    apb(1'b1, 12'h000, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
    input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, q, exp);
    check({nm, "_err"}, {31'h0, e}, {31'h0, experr});
  endtask

  // Outputs lag their causes by one cycle; allow a margin
  task automatic settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial
  begin
    #(20000 * 5);
    n_mismatch++;
    complete_run;
  end

  initial
  begin
    do_reset;
    rd("sc_reset", 12'h000, 32'h0780, 1'b0);
    check("ctrl_reset", {26'h0, ctrl}, 32'h0f);
    settle;
    check("sys_locked", {31'h0, sys_g}, 32'h0);
    check("ldr_locked", {31'h0, ldr_g}, 32'h0);
    @(posedge pclk);
    sys_m <= 1'b1;
    ldr_m <= 1'b1;
    settle;
    check("sys_match", {31'h0, sys_g}, 32'h1);
    check("ldr_match", {31'h0, ldr_g}, 32'h1);
    @(posedge pclk);
    sys_m <= 1'b0;
    ldr_m <= 1'b0;
    dbg_req <= 1'b1;
    ctx <= {1'b0, 2'b00, 16'h0000};
    settle;
    check("dbg_programmed", {31'h0, dbg_ref}, 32'h1);
    rd("status_dbg", 12'h004, 32'h2, 1'b0);
    @(posedge pclk);
    ctx <= {1'b0, 2'b00, 16'hffff};
    m_req <= 1'b1;
    settle;
    check("dbg_erased", {31'h0, dbg_ref}, 32'h0);
    check("acc_denied", {31'h0, acc_g}, 32'h0);
    check("fault_on", {31'h0, fault}, 32'h1);
    rd("status_fault", 12'h004, 32'h1, 1'b0);
    @(posedge pclk);
    rom_rd <= 1'b1;
    settle;
    check("rom_read", {31'h0, acc_g}, 32'h1);
    @(posedge pclk);
    rom_rd <= 1'b0;
    // Reserved and upper page bits stay zero; protected bits hold
    wr_ctx(1'b0, 2'b00, 32'hffff_ffff);
    rd("sc_ones", 12'h000, 32'h0790, 1'b0);
    check("ctrl_ones", {26'h0, ctrl}, 32'h1f);
    wr_ctx(1'b0, 2'b00, 32'h0);
    rd("sc_low", 12'h000, 32'h0700, 1'b0);
    wr_ctx(1'b1, 2'b01, 32'h0);
    rd("sc_med_rom", 12'h000, 32'h0500, 1'b0);
    wr_ctx(1'b0, 2'b10, 32'h0);
    rd("sc_high", 12'h000, 32'h0100, 1'b0);
    wr_ctx(1'b1, 2'b10, 32'h0);
    rd("sc_high_rom", 12'h000, 32'h0000, 1'b0);
    settle;
    check("sys_open", {31'h0, sys_g}, 32'h1);
    check("ldr_open", {31'h0, ldr_g}, 32'h1);
    check("acc_open", {31'h0, acc_g}, 32'h1);
    check("no_fault", {31'h0, fault}, 32'h0);
    wr_ctx(1'b0, 2'b00, 32'h0400);
    rd("sc_mpe_set", 12'h000, 32'h0400, 1'b0);
    settle;
    check("acc_again", {31'h0, acc_g}, 32'h0);
    rd("unmapped", 12'h008, 32'h0, 1'b1);
    @(posedge pclk);
    pstrb <= 4'h1;
    wr_ctx(1'b1, 2'b10, 32'h0000_0090);
    rd("sc_lane", 12'h000, 32'h0490, 1'b0);
    pstrb <= 4'hf;
    do_reset;
    rd("sc_rereset", 12'h000, 32'h0780, 1'b0);
    check("ctrl_rereset", {26'h0, ctrl}, 32'h0f);
    complete_run;
  end
endmodule // tb
